// *** pps_top.sv ***
// Three-channel programmable PWM sequencer with its register port.
// Assumes a register port already decoded from the serial bus, one
// byte per strobe, and a 32 kHz time base arriving from a pin.
`timescale 1ns/10ps
`include "pps_regs.svh"

module pps_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk32k_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic trigger_op_pin_i,
  output logic trigger_op_pin_o,
  output logic trigger_op_pin_oe_o,
  output logic [2:0] pwm_o,
  output logic [2:0] pwm_irq_o
);

  // --------------------------------------------------------------------
  // Shared state
  // --------------------------------------------------------------------
  logic [1:0] sync32_q, sync32_d;
  logic [1:0] trigger_op_sync_q, trigger_op_sync_d;
  logic c32_prev_q, c32_prev_d;
  logic [8:0] pre_q, pre_d;
  logic [7:0] pwm_cnt_q, pwm_cnt_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [2:0] inval_q, inval_d;
  logic [7:0] rdata_q, rdata_d;
  logic [6:0] hptr_q [3], hptr_d [3];
  logic [7:0] msb_q [3], msb_d [3];
  logic [2:0] pend_q [3], pend_d [3];
  logic [2:0] ext_pend_q, ext_pend_d;
  logic ext_hold_q, ext_hold_d;
  logic [2:0] pwm_out_q, pwm_out_d;
  logic [2:0] irq_q, irq_d;

  logic tick32, tick16, tick512;
  logic cs_wr;
  logic [2:0] port_sel;
  logic [2:0] store_we;
  logic [5:0] store_addr [3];
  logic [15:0] store_wdata [3];
  logic [15:0] store_rd [3];
  pps_pkg::pps_chan_s ch_q [3], ch_d [3];
  pps_pkg::pps_evt_s evt [3];

  assign tick32 = sync32_q[1] & ~c32_prev_q;
  assign tick16 = tick32 && ((pre_q & `PPS_DIV16_MASK) == `PPS_DIV16_MASK);
  assign tick512 = tick32 && (pre_q == `PPS_DIV512_MASK);
  assign cs_wr = reg_wr_i && (reg_addr_i == `PPS_ADDR_CS);

  assign reg_rdata_o = rdata_q;
  assign trigger_op_pin_o = ~ext_hold_q;
  assign trigger_op_pin_oe_o = ctrl_q[`PPS_CS_EXT_EN] & ctrl_q[`PPS_CS_EXT_DIR];
  assign pwm_o = pwm_out_q;
  assign pwm_irq_o = irq_q;

  // --------------------------------------------------------------------
  // Shared next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    logic ext_in_en;
    ext_in_en = ctrl_q[`PPS_CS_EXT_EN] & ~ctrl_q[`PPS_CS_EXT_DIR];
    // Only the second stage of each synchroniser is looked at
    sync32_d = {sync32_q[0], clk32k_i};
    trigger_op_sync_d = {trigger_op_sync_q[0], trigger_op_pin_i};
    c32_prev_d = sync32_q[1];
    pre_d = tick32 ? pre_q + 9'h001 : pre_q;
    pwm_cnt_d = pwm_cnt_q + 8'h01;
    ctrl_d = cs_wr ? (reg_wdata_i & `PPS_CS_WR_MASK) : ctrl_q;
    inval_d = inval_q;
    rdata_d = rdata_q;
    ext_pend_d = ext_pend_q;
    ext_hold_d = tick32 ? 1'b0 : ext_hold_q;
    for (int c = 0; c < `PPS_NUM_CH; c++) begin
      port_sel[c] = (reg_addr_i == (`PPS_ADDR_IC0 + 8'(c)));
      // Channel stop by hardware overrides a host write in the same cycle
      if (evt[c].done || evt[c].invalid) begin
        ctrl_d[c] = 1'b0;
      end
      if (cs_wr && reg_wdata_i[c]) begin
        inval_d[c] = 1'b0;
      end
      if (evt[c].invalid) begin
        inval_d[c] = 1'b1;
      end
      hptr_d[c] = hptr_q[c];
      msb_d[c] = msb_q[c];
      store_we[c] = 1'b0;
      if (cs_wr && reg_wdata_i[c] && !ctrl_q[c]) begin
        hptr_d[c] = 7'h00;
      end else if ((reg_wr_i || reg_rd_i) && port_sel[c] && !ctrl_q[c]) begin
        hptr_d[c] = hptr_q[c] + 7'h01;
        if (reg_wr_i && !hptr_q[c][0]) begin
          msb_d[c] = reg_wdata_i;
        end
        store_we[c] = reg_wr_i && hptr_q[c][0];
      end
      store_addr[c] = ctrl_q[c] ? ch_q[c].pc : hptr_q[c][6:1];
      store_wdata[c] = {msb_q[c], reg_wdata_i};
      pend_d[c] = pend_q[c] & ~evt[c].consume;
      for (int s = 0; s < `PPS_NUM_CH; s++) begin
        if (evt[s].send[c]) begin
          pend_d[c][s] = 1'b1;
        end
      end
      if (!ctrl_q[c]) begin
        pend_d[c] = 3'h0;
      end
      if (evt[c].ext_consume || !ctrl_q[c]) begin
        ext_pend_d[c] = 1'b0;
      end
      if (ext_in_en && trigger_op_sync_q[1] && ctrl_q[c]) begin
        ext_pend_d[c] = 1'b1;
      end
      if (evt[c].ext_send && trigger_op_pin_oe_o) begin
        ext_hold_d = 1'b1;
      end
      pwm_out_d[c] = ctrl_q[c] && (pwm_cnt_q < ch_q[c].pwm);
      irq_d[c] = evt[c].done;
    end
    if (reg_rd_i) begin
      rdata_d = 8'h00;
      if (reg_addr_i == `PPS_ADDR_CS) begin
        rdata_d = {ctrl_q[7:6], inval_q, ctrl_q[2:0]};
      end
      for (int c = 0; c < `PPS_NUM_CH; c++) begin
        if (port_sel[c] && !ctrl_q[c]) begin
          rdata_d = hptr_q[c][0] ? store_rd[c][7:0] : store_rd[c][15:8];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync32_q <= 2'h0;
      trigger_op_sync_q <= 2'h0;
      c32_prev_q <= 1'b0;
      pre_q <= 9'h000;
      pwm_cnt_q <= 8'h00;
      ctrl_q <= `PPS_CS_RESET;
      inval_q <= 3'h0;
      rdata_q <= 8'h00;
      for (int c = 0; c < `PPS_NUM_CH; c++) begin
        hptr_q[c] <= 7'h00;
        msb_q[c] <= 8'h00;
        pend_q[c] <= 3'h0;
      end
      ext_pend_q <= 3'h0;
      ext_hold_q <= 1'b0;
      pwm_out_q <= 3'h0;
      irq_q <= 3'h0;
    end else begin
      sync32_q <= sync32_d;
      trigger_op_sync_q <= trigger_op_sync_d;
      c32_prev_q <= c32_prev_d;
      pre_q <= pre_d;
      pwm_cnt_q <= pwm_cnt_d;
      ctrl_q <= ctrl_d;
      inval_q <= inval_d;
      rdata_q <= rdata_d;
      for (int c = 0; c < `PPS_NUM_CH; c++) begin
        hptr_q[c] <= hptr_d[c];
        msb_q[c] <= msb_d[c];
        pend_q[c] <= pend_d[c];
      end
      ext_pend_q <= ext_pend_d;
      ext_hold_q <= ext_hold_d;
      pwm_out_q <= pwm_out_d;
      irq_q <= irq_d;
    end
  end

  // --------------------------------------------------------------------
  // Per-channel sequencer
  // --------------------------------------------------------------------
  for (genvar g = 0; g < `PPS_NUM_CH; g++) begin : g_ch
    pps_store u_store (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .addr_i(store_addr[g]),
      .we_i(store_we[g]),
      .wdata_i(store_wdata[g]),
      .rdata_o(store_rd[g])
    );
    always_comb begin
      logic [15:0] ins;
      logic tick;
      logic ready;
      logic [5:0] target;
      ins = store_rd[g];
      ch_d[g] = ch_q[g];
      evt[g] = '0;
      tick = ins[`PPS_RAMP_PRESC] ? tick512 : tick16;
      target = ins[`PPS_BR_REL] ? ch_q[g].pc + ins[`PPS_BR_STEP] :
               ins[`PPS_BR_STEP];
      // Wait on external input only counts when the pin is an input
      ready = ((ins[`PPS_TRG_WAIT] & ~pend_q[g]) == 3'h0) &&
              (!ins[`PPS_TRG_WEXT] || ext_pend_q[g] ||
               !(ctrl_q[`PPS_CS_EXT_EN] &&
               !ctrl_q[`PPS_CS_EXT_DIR]));
      case (ch_q[g].state)
        pps_pkg::PPS_ST_RESET: begin
          ch_d[g].pc = `PPS_PC_START;
          ch_d[g].loop_run = 1'b0;
          if (ctrl_q[g]) begin
            ch_d[g].state = pps_pkg::PPS_ST_FETCH;
          end
        end
        pps_pkg::PPS_ST_FETCH: begin
          ch_d[g].state = pps_pkg::PPS_ST_EXEC;
        end
        pps_pkg::PPS_ST_EXEC: begin
          ch_d[g].state = pps_pkg::PPS_ST_FETCH;
          ch_d[g].pc = ch_q[g].pc + 6'h01;
          if (!ins[`PPS_OP_MSB]) begin
            if (ins[`PPS_RAMP_STEP] != 6'h00) begin
              ch_d[g].steps = ins[`PPS_RAMP_INC];
              ch_d[g].tmr = 6'h00;
              if (ins[`PPS_RAMP_INC] != 7'h00) begin
                ch_d[g].pc = ch_q[g].pc;
                ch_d[g].state = pps_pkg::PPS_ST_RAMP;
              end
            end else if (ins[`PPS_LOAD_SEL]) begin
              ch_d[g].pwm = ins[`PPS_LOAD_VAL];
            end else begin
              ch_d[g].pc = `PPS_PC_START;
            end
          end else begin
            case (ins[`PPS_OP])
              `PPS_OP_BRANCH: begin
                if (ins[`PPS_BR_LOOP] == 6'h00) begin
                  ch_d[g].pc = target;
                end else if (!ch_q[g].loop_run) begin
                  ch_d[g].loops = ins[`PPS_BR_LOOP] - 6'h01;
                  ch_d[g].loop_run = 1'b1;
                  ch_d[g].pc = target;
                end else if (ch_q[g].loops != 6'h00) begin
                  ch_d[g].loops = ch_q[g].loops - 6'h01;
                  ch_d[g].pc = target;
                end else begin
                  ch_d[g].loop_run = 1'b0;
                end
              end
              `PPS_OP_END: begin
                evt[g].done = 1'b1;
                ch_d[g].state = pps_pkg::PPS_ST_RESET;
              end
              `PPS_OP_TRIGGER_OP: begin
                ch_d[g].pc = ch_q[g].pc;
                ch_d[g].state = pps_pkg::PPS_ST_WAIT;
              end
              default: begin
                evt[g].invalid = 1'b1;
                ch_d[g].state = pps_pkg::PPS_ST_RESET;
              end
            endcase
          end
        end
        pps_pkg::PPS_ST_RAMP: begin
          if (tick) begin
            ch_d[g].tmr = ch_q[g].tmr + 6'h01;
            if (ch_q[g].tmr + 6'h01 == ins[`PPS_RAMP_STEP]) begin
              ch_d[g].tmr = 6'h00;
              ch_d[g].steps = ch_q[g].steps - 7'h01;
              // Saturate rather than wrap, avoids a visible flash
              if (!ins[`PPS_RAMP_SIGN] && ch_q[g].pwm != `PPS_PWM_MAX) begin
                ch_d[g].pwm = ch_q[g].pwm + 8'h01;
              end else if (ins[`PPS_RAMP_SIGN] && ch_q[g].pwm != 8'h00) begin
                ch_d[g].pwm = ch_q[g].pwm - 8'h01;
              end
              if (ch_q[g].steps == 7'h01) begin
                ch_d[g].pc = ch_q[g].pc + 6'h01;
                ch_d[g].state = pps_pkg::PPS_ST_FETCH;
              end
            end
          end
        end
        pps_pkg::PPS_ST_WAIT: begin
          if (ready) begin
            evt[g].consume = ins[`PPS_TRG_WAIT];
            evt[g].ext_consume = ins[`PPS_TRG_WEXT];
            evt[g].send = ins[`PPS_TRG_SEND];
            evt[g].ext_send = ins[`PPS_TRG_SEXT];
            ch_d[g].pc = ch_q[g].pc + 6'h01;
            ch_d[g].state = pps_pkg::PPS_ST_FETCH;
          end
        end
        default: begin
          ch_d[g].state = pps_pkg::PPS_ST_RESET;
        end
      endcase
      if (!ctrl_q[g]) begin
        ch_d[g] = '0;
        evt[g] = '0;
      end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        ch_q[g] <= '0;
      end else begin
        ch_q[g] <= ch_d[g];
      end
    end
  end

endmodule : pps_top

// *** pps_regs.svh ***
// Register addresses, field positions and counts of the PWM sequencer.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PPS_ADDR_CS 8'h30
`define PPS_ADDR_IC0 8'h38
`define PPS_NUM_CH 3
`define PPS_CS_RESET 8'h00
`define PPS_CS_WR_MASK 8'hC7
`define PPS_CS_EXT_EN 6
`define PPS_CS_EXT_DIR 7

// ----------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------
`define PPS_OP 15:13
`define PPS_OP_MSB 15
`define PPS_OP_BRANCH 3'h5
`define PPS_OP_END 3'h6
`define PPS_OP_TRIGGER_OP 3'h7
`define PPS_RAMP_PRESC 14
`define PPS_RAMP_STEP 13:8
`define PPS_RAMP_SIGN 7
`define PPS_RAMP_INC 6:0
`define PPS_LOAD_SEL 14
`define PPS_LOAD_VAL 7:0
`define PPS_BR_LOOP 12:7
`define PPS_BR_REL 6
`define PPS_BR_STEP 5:0
`define PPS_TRG_WAIT 9:7
`define PPS_TRG_WEXT 12
`define PPS_TRG_SEND 3:1
`define PPS_TRG_SEXT 6

// ----------------------------------------------------------------------
// Time base and store
// ----------------------------------------------------------------------
`define PPS_DIV16_MASK 9'h00F
`define PPS_DIV512_MASK 9'h1FF
`define PPS_PWM_MAX 8'hFF
`define PPS_PC_START 6'h00
`define PPS_STORE_WORDS 64

`endif

// *** pps_pkg.sv ***
// Types shared by the PWM sequencer files.
// Assumes constants come from pps_regs.svh.
package pps_pkg;

  typedef enum logic [2:0] {
    PPS_ST_RESET = 3'b000,
    PPS_ST_FETCH = 3'b001,
    PPS_ST_EXEC = 3'b010,
    PPS_ST_RAMP = 3'b011,
    PPS_ST_WAIT = 3'b100
  } pps_state_e;

  typedef struct packed {
    pps_state_e state;
    logic [5:0] pc;
    logic [7:0] pwm;
    logic [6:0] steps;
    logic [5:0] tmr;
    logic [5:0] loops;
    logic loop_run;
  } pps_chan_s;

  typedef struct packed {
    logic [2:0] send;
    logic [2:0] consume;
    logic ext_consume;
    logic ext_send;
    logic done;
    logic invalid;
  } pps_evt_s;

endpackage : pps_pkg

// *** pps_store.sv ***
// Program store of one channel: 64 words of 16 bits.
// Assumes one writer and one reader on core_clk_i; read data registered.
`timescale 1ns/10ps
`include "pps_regs.svh"

module pps_store (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] addr_i,
  input wire logic we_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);

  logic [15:0] mem_q [`PPS_STORE_WORDS];

  // Cleared by reset: an unloaded word reads zero and acts as go-to-start
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `PPS_STORE_WORDS; i++) begin
        mem_q[i] <= 16'h0000;
      end
      rdata_o <= 16'h0000;
    end else begin
      if (we_i) begin
        mem_q[addr_i] <= wdata_i;
      end
      rdata_o <= mem_q[addr_i];
    end
  end

endmodule : pps_store

// *** pps_assertions.sv ***
// Port-level checks of the PWM sequencer top.
// Assumes it is bound onto pps_top; one clock, async active-low reset.
`timescale 1ns/10ps
`include "pps_regs.svh"

module pps_assertions (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic trigger_op_pin_o,
  input wire logic trigger_op_pin_oe_o,
  input wire logic [2:0] pwm_o,
  input wire logic [2:0] pwm_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [1:0] ext_q;
  always_ff @(posedge core_clk_i) begin
    ext_q <= reg_wdata_i[7:6];
  end

  sequence s_cs_wr;
    reg_wr_i && reg_addr_i == `PPS_ADDR_CS;
  endsequence
  sequence s_quiet;
    (pwm_o == 3'h0) [*4];
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_reset_quiet: assert property ($rose(rst_n_i) |-> pwm_o == 3'h0 &&
    pwm_irq_o == 3'h0 && trigger_op_pin_o && !trigger_op_pin_oe_o &&
    reg_rdata_o == 8'h00) else $error("outputs not idle after reset");
  a_oe_follows: assert property (s_cs_wr |=>
    trigger_op_pin_oe_o == (ext_q[1] & ext_q[0]))
    else $error("trigger pin enable not from control write");
  a_oe_holds: assert property (!(reg_wr_i && reg_addr_i == `PPS_ADDR_CS)
    |=> $stable(trigger_op_pin_oe_o)) else $error("trigger enable moved alone");
  a_irq_single: assert property (|pwm_irq_o |=>
    (pwm_irq_o & $past(pwm_irq_o)) == 3'h0) else $error("irq too long");
  a_irq_quiets: assert property (pwm_irq_o[0] |=> ##1 (!pwm_o[0]) [*4])
    else $error("channel output high after end");
  a_rdata_holds: assert property (!$past(reg_rd_i) |->
    $stable(reg_rdata_o)) else $error("read data moved without read");
  a_unmapped_zero: assert property (reg_rd_i && !(reg_addr_i inside
    {`PPS_ADDR_CS, `PPS_ADDR_IC0, 8'h39, 8'h3A}) |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_disable_quiets: assert property (s_cs_wr ##0
    reg_wdata_i[2:0] == 3'h0 |-> ##3 s_quiet)
    else $error("output active with all channels disabled");
endmodule : pps_assertions

bind pps_top pps_assertions i_chk (.core_clk_i, .rst_n_i, .reg_addr_i,
  .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .trigger_op_pin_o,
  .trigger_op_pin_oe_o, .pwm_o, .pwm_irq_o);

// *** pps_host_model.sv ***
// Host model: byte-wide register accesses on the decoded port.
// Assumes a bench that calls its tasks and drives nothing else here.
`timescale 1ns/10ps

module pps_host_model (
  input wire logic core_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o,
  output logic rd_done_o,
  output logic [7:0] rd_byte_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
    rd_done_o = 1'b0;
    rd_byte_o = 8'h00;
  end

  // Released lines flip so a stale value is never mistaken for data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge core_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr

  task automatic wr_word(input logic [7:0] a, input logic [15:0] w);
    wr(a, w[15:8]);
    wr(a, w[7:0]);
  endtask : wr_word

  task automatic rd(input logic [7:0] a);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge core_clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    @(posedge core_clk_i);
    rd_byte_o = reg_rdata_i;
    rd_done_o = 1'b1;
    @(negedge core_clk_i);
    rd_done_o = 1'b0;
  endtask : rd
endmodule : pps_host_model

// *** test_programmable_pwm_sequencer.sv ***
// Self-checking bench of the three-channel PWM sequencer.
// Assumes pps_top, pps_host_model and the bound checker are compiled.
`timescale 1ns/10ps
`include "pps_regs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("[ERR] %0t got %h want %h", $time, g, e); end end

module test_programmable_pwm_sequencer;
  logic core_clk_i, rst_n_i, clk32k_i, trigger_op_pin_i;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_byte, v, e;
  logic reg_wr, reg_rd, trigger_op_o, trigger_op_oe, rd_done;
  logic [2:0] pwm, irq, irq_seen;
  logic [8:0] c;
  logic [7:0] exp_q[$];
  int mismatches, samples_checked, n;

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // Time base runs fast (20 core cycles) to keep ramps short
  initial begin
    clk32k_i = 1'b0;
    forever #100 clk32k_i = ~clk32k_i;
  end

  pps_top i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .clk32k_i(clk32k_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .trigger_op_pin_i(trigger_op_pin_i), .trigger_op_pin_o(trigger_op_o),
    .trigger_op_pin_oe_o(trigger_op_oe), .pwm_o(pwm), .pwm_irq_o(irq));
  pps_host_model i_host (.core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata),
    .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_wdata_o(reg_wdata), .rd_done_o(rd_done), .rd_byte_o(rd_byte));

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) irq_seen <= irq_seen | irq;
  always @(posedge rd_done) begin
    e = exp_q.pop_front();
    `CHK(rd_byte, e)
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    i_host.rd(a);
  endtask : rd

  task automatic wait_irq(input int k, input int lim);
    for (n = 0; n < lim && !irq_seen[k]; n++) @(negedge core_clk_i);
    `CHK(irq_seen[k], 1'b1)
    if (!irq_seen[k]) complete_run();
  endtask : wait_irq

  task automatic duty(input int k);
    c = 9'h000;
    repeat (256) begin
      @(negedge core_clk_i);
      c = c + 9'(pwm[k]);
    end
  endtask : duty

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    trigger_op_pin_i = 1'b0;
    irq_seen = 3'h0;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(32'h2AC4));
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i) rst_n_i = 1'b1;
    rd(`PPS_ADDR_CS, 8'h00);
    rd(8'h31, 8'h00);
    rd(8'h3A, 8'h00);
    rd(8'h3A, 8'h00);
    `CHK(pwm, 3'h0)
    $display("test reset done");
    // Channel 0 still disabled while loading
    v = 8'($urandom);
    i_host.wr_word(`PPS_ADDR_IC0, {8'h40, v});
    i_host.wr_word(`PPS_ADDR_IC0, 16'hE100);
    i_host.wr_word(`PPS_ADDR_IC0, 16'hC000);
    i_host.wr(`PPS_ADDR_CS, 8'h01);
    repeat (20) @(negedge core_clk_i);
    duty(0);
    `CHK(c, {1'b0, v})
    `CHK(irq_seen, 3'h0)
    i_host.wr_word(`PPS_ADDR_IC0, {~v, v});
    rd(`PPS_ADDR_IC0, 8'h00);
    i_host.wr(`PPS_ADDR_CS, 8'h00);
    rd(`PPS_ADDR_IC0, 8'h40);
    rd(`PPS_ADDR_IC0, v);
    rd(`PPS_ADDR_IC0, 8'hE1);
    $display("test load done");
    i_host.wr_word(8'h39, 16'h4010);
    i_host.wr_word(8'h39, 16'h0184);
    i_host.wr_word(8'h39, 16'hE002);
    i_host.wr_word(8'h39, 16'hE200);
    irq_seen = 3'h0;
    i_host.wr(`PPS_ADDR_CS, 8'h03);
    repeat (900) @(negedge core_clk_i);
    `CHK(irq_seen, 3'h0)
    wait_irq(0, 1000);
    duty(1);
    `CHK(c, 9'h00C)
    `CHK(irq_seen[1], 1'b0)
    rd(8'h39, 8'h00);
    i_host.wr(`PPS_ADDR_CS, 8'h00);
    $display("test ramp done");
    i_host.wr_word(8'h39, 16'h0101);
    i_host.wr_word(8'h39, 16'hA083);
    i_host.wr_word(8'h39, 16'hE200);
    i_host.wr_word(8'h39, 16'h0000);
    i_host.wr(`PPS_ADDR_CS, 8'h02);
    repeat (800) @(negedge core_clk_i);
    duty(1);
    `CHK(c, 9'h002)
    i_host.wr(`PPS_ADDR_CS, 8'h00);
    $display("test branch done");
    for (n = 0; n < 65; n++) i_host.wr_word(8'h3A, 16'h4000 | 16'(n));
    i_host.wr(`PPS_ADDR_CS, 8'h04);
    i_host.wr(`PPS_ADDR_CS, 8'h00);
    rd(8'h3A, 8'h40);
    rd(8'h3A, 8'h3F);
    i_host.wr(`PPS_ADDR_CS, 8'h04);
    i_host.wr(`PPS_ADDR_CS, 8'h00);
    i_host.wr_word(8'h3A, 16'h8000);
    i_host.wr(`PPS_ADDR_CS, 8'h04);
    repeat (10) @(negedge core_clk_i);
    rd(`PPS_ADDR_CS, 8'h20);
    i_host.wr(`PPS_ADDR_CS, 8'hF8);
    rd(`PPS_ADDR_CS, 8'hE0);
    `CHK({trigger_op_oe, trigger_op_o}, 2'h3)
    $display("test invalid done");
    i_host.wr_word(8'h3A, 16'hE040);
    i_host.wr_word(8'h3A, 16'hC000);
    irq_seen = 3'h0;
    i_host.wr(`PPS_ADDR_CS, 8'hC4);
    for (n = 0; n < 30 && trigger_op_o; n++) @(negedge core_clk_i);
    `CHK(trigger_op_o, 1'b0)
    if (trigger_op_o !== 1'b0) complete_run();
    wait_irq(2, 50);
    repeat (40) @(negedge core_clk_i);
    `CHK(trigger_op_o, 1'b1)
    rd(`PPS_ADDR_CS, 8'hC0);
    $display("test trigger out done");
    i_host.wr_word(`PPS_ADDR_IC0, 16'hF000);
    i_host.wr_word(`PPS_ADDR_IC0, 16'hC000);
    irq_seen = 3'h0;
    i_host.wr(`PPS_ADDR_CS, 8'h41);
    repeat (100) @(negedge core_clk_i);
    `CHK(irq_seen, 3'h0)
    trigger_op_pin_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    trigger_op_pin_i = 1'b0;
    wait_irq(0, 50);
    $display("test trigger in done");
    complete_run();
  end
endmodule : test_programmable_pwm_sequencer
